// ### tmc_pkg.sv
// constants and types shared by the timer mode, clock and capture control block
// assumes a single core clock; nothing here holds state
package tmc_pkg;

	// register byte offsets on the bus
	localparam logic [7:0]  ADDR_MODE_CLOCK_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_FORCE_COMPARE     = 8'h04;
	localparam logic [7:0]  ADDR_MODE_LOW_CTRL     = 8'h08;
	localparam logic [7:0]  ADDR_CAPTURE_VALUE     = 8'h0c;
	localparam logic [7:0]  ADDR_IRQ_STATUS        = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK          = 8'h14;

	// mode and clock control field positions
	localparam int          CTRL_FILTER_BIT        = 7;
	localparam int          CTRL_EDGE_BIT          = 6;
	localparam int          CTRL_WGM_HI_LSB        = 3;
	localparam int          CTRL_CS_LSB            = 0;
	localparam logic [7:0]  CTRL_WRITE_MASK        = 8'hdf;
	localparam logic [7:0]  CTRL_RESET             = 8'h00;
	localparam logic [1:0]  MODE_LOW_RESET         = 2'h0;

	// force compare strobes
	localparam int          FORCE_A_BIT            = 7;
	localparam int          FORCE_B_BIT            = 6;

	// interrupt status and mask layout
	localparam int          STAT_CAPTURE_BIT       = 0;
	localparam logic        STAT_RESET             = 1'b0;
	localparam logic        MASK_RESET             = 1'b0;

	// capture filter
	localparam int          FILTER_SAMPLES         = 4;

	// clock select codes
	localparam logic [2:0]  CS_STOPPED             = 3'h0;
	localparam logic [2:0]  CS_DIV1                = 3'h1;
	localparam logic [2:0]  CS_DIV8                = 3'h2;
	localparam logic [2:0]  CS_DIV64               = 3'h3;
	localparam logic [2:0]  CS_DIV256              = 3'h4;
	localparam logic [2:0]  CS_DIV1024             = 3'h5;
	localparam logic [2:0]  CS_EXT_FALL            = 3'h6;
	localparam logic [2:0]  CS_EXT_RISE            = 3'h7;
	localparam int          PRESC_W                = 10;
	localparam int          LOG2_DIV8              = 3;
	localparam int          LOG2_DIV64             = 6;
	localparam int          LOG2_DIV256            = 8;
	localparam int          LOG2_DIV1024           = 10;

	// fixed top values
	localparam logic [15:0] TOP_MAX                = 16'hffff;
	localparam logic [15:0] TOP_8BIT               = 16'h00ff;
	localparam logic [15:0] TOP_9BIT               = 16'h01ff;
	localparam logic [15:0] TOP_10BIT              = 16'h03ff;

	typedef enum logic [2:0] {
		WK_NORMAL,
		WK_CTC,
		WK_PC_PWM,
		WK_PFC_PWM,
		WK_FAST_PWM,
		WK_RESERVED
	} tmc_wave_kind_t;

	typedef enum logic [1:0] {
		EP_IMMEDIATE,
		EP_TOP,
		EP_BOTTOM,
		EP_MAX
	} tmc_point_t;

	typedef enum logic [1:0] {
		TS_FIXED,
		TS_COMPARE_A,
		TS_CAPTURE
	} tmc_top_src_t;

	typedef struct packed {
		tmc_wave_kind_t kind;
		tmc_top_src_t   top_src;
		logic [15:0]    fixed_top;
		tmc_point_t     update_at;
		tmc_point_t     overflow_at;
	} tmc_mode_t;

endpackage : tmc_pkg

// ### tmc_cap_if.sv
// carries the synchronised capture input to the filter and the filtered level back
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface tmc_cap_if;
	logic sample;
	logic filter_en;
	logic filtered;

	modport ctrl (output sample, output filter_en, input filtered);
	modport filt (input sample, input filter_en, output filtered);
endinterface : tmc_cap_if
`default_nettype wire

// ### tmc_cap_filter.sv
// capture input noise filter: output follows the input only after a run of equal samples
// assumes the sample input is already synchronised to the core clock
`timescale 1ns/1ps
`default_nettype none
module tmc_cap_filter (
	input  wire logic    clk,
	input  wire logic    rst_n,
	tmc_cap_if.filt      cap
);
	typedef struct packed {
		logic [tmc_pkg::FILTER_SAMPLES-1:0] hist;
		logic                               level;
	} tmc_filt_state_t;

	tmc_filt_state_t st_reg;
	tmc_filt_state_t st_next;

	always_comb
	begin
		st_next      = st_reg;
		st_next.hist = {st_reg.hist[tmc_pkg::FILTER_SAMPLES-2:0], cap.sample};
		if (!cap.filter_en)
		begin
			st_next.level = cap.sample;
		end
		// all stored samples agree: only then the level may move
		else if (&st_next.hist || ~|st_next.hist)
		begin
			st_next.level = st_next.hist[0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign cap.filtered = st_reg.level;

endmodule : tmc_cap_filter
`default_nettype wire

// ### tmc_timer_ctrl.sv
// timer mode decode, clock select, input capture and force compare control
// assumes an AHB-Lite master on CORE_CLK, counter and compare A from the datapath
// on the same clock, and capture and count pins arriving asynchronously
//
// Overview of operation
// - decode four-bit mode; normal, clear-on-match, reserved
// - phase correct: fixed or register top
// - phase-frequency correct: update and overflow at bottom
// - filter needs four equal samples when enabled
// - edge select: zero falling, one rising
// - capture copies counter, sets capture flag
// - capture disconnected when capture register is top
// - clock select: stop, or prescaled core clock
// - codes six, seven: external pin edges
// - external pin counts even when driven out
// - force bits act only in non-pwm modes
// - force bit pulses immediate compare match
// - forced match gives no interrupt, no clear
// - force bits are strobes, read zero
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_ctrl (
	input  wire logic                  CORE_CLK,
	input  wire logic                  RESETN,
	// ahb-lite slave
	input  wire logic                  HSEL,
	input  wire logic [31:0]           HADDR,
	input  wire logic [1:0]            HTRANS,
	input  wire logic                  HWRITE,
	input  wire logic [2:0]            HSIZE,
	input  wire logic [31:0]           HWDATA,
	input  wire logic                  HREADY,
	output logic      [31:0]           HRDATA,
	output logic                       HREADYOUT,
	output logic                       HRESP,
	// counter datapath
	input  wire logic [15:0]           COUNTER_VALUE,
	input  wire logic [15:0]           COMPARE_A_VALUE,
	output logic                       COUNT_TICK,
	output logic [15:0]                TOP_VALUE,
	output tmc_pkg::tmc_wave_kind_t    WAVE_KIND,
	output tmc_pkg::tmc_point_t        COMPARE_UPDATE_AT,
	output tmc_pkg::tmc_point_t        OVERFLOW_AT,
	output logic                       FORCE_MATCH_A,
	output logic                       FORCE_MATCH_B,
	output logic                       CAPTURE_EVENT,
	output logic [15:0]                CAPTURE_VALUE,
	// pins
	input  wire logic                  CAPTURE_INPUT,
	input  wire logic                  EXT_COUNT_INPUT,
	output logic                       IRQ
);
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	// whole block state: one comb copy, one register
	typedef struct packed {
		logic [7:0]                    ctrl;
		logic [1:0]                    mode_low;
		logic                          stat;
		logic                          mask;
		logic [15:0]                   cap_val;
		logic [tmc_pkg::PRESC_W-1:0]   presc;
		logic                          ext_s1;
		logic                          ext_s2;
		logic                          ext_prev;
		logic                          cap_s1;
		logic                          cap_s2;
		logic                          filt_prev;
		logic                          wr_pend;
		logic [7:0]                    wr_addr;
		logic [31:0]                   rdata;
		logic                          ready;
		logic                          resp;
		logic                          tick;
		logic [15:0]                   top;
		tmc_pkg::tmc_mode_t            mode;
		logic                          force_a;
		logic                          force_b;
		logic                          cap_evt;
		logic                          irq;
	} tmc_state_t;

	// bus ready at once, top at full range, normal counting
	localparam tmc_state_t ST_RESET = '{
		ctrl:     tmc_pkg::CTRL_RESET,
		mode_low: tmc_pkg::MODE_LOW_RESET,
		stat:     tmc_pkg::STAT_RESET,
		mask:     tmc_pkg::MASK_RESET,
		ready:    1'b1,
		top:      tmc_pkg::TOP_MAX,
		mode:     '{kind: tmc_pkg::WK_NORMAL, top_src: tmc_pkg::TS_FIXED,
		            fixed_top: tmc_pkg::TOP_MAX, update_at: tmc_pkg::EP_IMMEDIATE,
		            overflow_at: tmc_pkg::EP_MAX},
		default:  '0
	};

	tmc_state_t st_reg;
	tmc_state_t st_next;

	// the filter has its own interface so its depth can change alone
	tmc_cap_if cap_bus ();

	tmc_cap_filter u_filter (
		.clk   (CORE_CLK),
		.rst_n (RESETN),
		.cap   (cap_bus.filt)
	);

	// full mode table; reserved code behaves like normal counting but is flagged
	function automatic tmc_pkg::tmc_mode_t decode_mode(input logic [3:0] wgm);
		tmc_pkg::tmc_mode_t m;
		m.kind        = tmc_pkg::WK_NORMAL;
		m.top_src     = tmc_pkg::TS_FIXED;
		m.fixed_top   = tmc_pkg::TOP_MAX;
		m.update_at   = tmc_pkg::EP_IMMEDIATE;
		m.overflow_at = tmc_pkg::EP_MAX;
		// first pass: counting family and its two event points
		case (wgm)
			4'h0: m.kind = tmc_pkg::WK_NORMAL;
			4'h4:
			begin
				m.kind    = tmc_pkg::WK_CTC;
				m.top_src = tmc_pkg::TS_COMPARE_A;
			end
			4'hc:
			begin
				m.kind    = tmc_pkg::WK_CTC;
				m.top_src = tmc_pkg::TS_CAPTURE;
			end
			4'hd: m.kind = tmc_pkg::WK_RESERVED;
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb:
			begin
				m.kind        = tmc_pkg::WK_PC_PWM;
				m.update_at   = tmc_pkg::EP_TOP;
				m.overflow_at = tmc_pkg::EP_BOTTOM;
			end
			4'h8, 4'h9:
			begin
				m.kind        = tmc_pkg::WK_PFC_PWM;
				m.update_at   = tmc_pkg::EP_BOTTOM;
				m.overflow_at = tmc_pkg::EP_BOTTOM;
			end
			default:
			begin
				m.kind        = tmc_pkg::WK_FAST_PWM;
				m.update_at   = tmc_pkg::EP_TOP;
				m.overflow_at = tmc_pkg::EP_TOP;
			end
		endcase
		// width and top source follow the low bits in the pwm families
		case (wgm)
			4'h1, 4'h5: m.fixed_top = tmc_pkg::TOP_8BIT;
			4'h2, 4'h6: m.fixed_top = tmc_pkg::TOP_9BIT;
			4'h3, 4'h7: m.fixed_top = tmc_pkg::TOP_10BIT;
			4'h8, 4'ha, 4'he: m.top_src = tmc_pkg::TS_CAPTURE;
			4'h9, 4'hb, 4'hf: m.top_src = tmc_pkg::TS_COMPARE_A;
			default: m.fixed_top = m.fixed_top;
		endcase
		return m;
	endfunction : decode_mode

	// reserved counts as pwm, so force strobes stay off there
	function automatic logic is_pwm(input tmc_pkg::tmc_wave_kind_t k);
		return (k == tmc_pkg::WK_PC_PWM) || (k == tmc_pkg::WK_PFC_PWM) ||
			(k == tmc_pkg::WK_FAST_PWM) || (k == tmc_pkg::WK_RESERVED);
	endfunction : is_pwm

	// a divide by two to the n hits once every 2^n cycles
	function automatic logic presc_hit(input logic [tmc_pkg::PRESC_W-1:0] p, input int n);
		logic [tmc_pkg::PRESC_W-1:0] m;
		m = tmc_pkg::PRESC_W'((1 << n) - 1);
		return (p & m) == m;
	endfunction : presc_hit

	// force strobes and unmapped offsets read as zero
	function automatic logic [31:0] read_word(input tmc_state_t s, input logic [7:0] a);
		logic [31:0] w;
		w = '0;
		case (a)
			tmc_pkg::ADDR_MODE_CLOCK_CTRL: w[7:0] = s.ctrl;
			tmc_pkg::ADDR_FORCE_COMPARE:   w = '0;
			tmc_pkg::ADDR_MODE_LOW_CTRL:   w[1:0] = s.mode_low;
			tmc_pkg::ADDR_CAPTURE_VALUE:   w[15:0] = s.cap_val;
			tmc_pkg::ADDR_IRQ_STATUS:      w[tmc_pkg::STAT_CAPTURE_BIT] = s.stat;
			tmc_pkg::ADDR_IRQ_MASK:        w[tmc_pkg::STAT_CAPTURE_BIT] = s.mask;
			default:                       w = '0;
		endcase
		return w;
	endfunction : read_word

	// data-phase write strobe for one register offset
	function automatic logic wr_hit(input tmc_state_t s, input logic [7:0] a);
		return s.wr_pend && (s.wr_addr == a);
	endfunction : wr_hit

	// edge of a registered level against its previous sample
	function automatic logic edge_seen(input logic lvl, input logic prv, input logic up);
		return up ? (lvl && !prv) : (!lvl && prv);
	endfunction : edge_seen

	// decoded views of the registers, rebuilt every cycle
	logic        addr_valid;
	logic [3:0]  wgm;
	logic [2:0]  cs;
	logic        cap_edge;
	logic        ext_rise;
	logic        ext_fall;
	logic        wr_ctrl;
	logic        wr_force;
	logic        wr_low;
	logic        wr_stat;
	logic        wr_mask;
	logic        cap_from_pin;
	tmc_pkg::tmc_mode_t mode_now;

	// the filter reads only the second synchroniser stage
	assign cap_bus.sample    = st_reg.cap_s2;
	assign cap_bus.filter_en = st_reg.ctrl[tmc_pkg::CTRL_FILTER_BIT];

	always_comb
	begin
		st_next = st_reg;

		// bus address phase: zero wait states, so HREADY is always our own
		addr_valid = HSEL && HREADY &&
			(HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);
		st_next.ready   = 1'b1;
		// no error response exists; kept in a flop so the pin is registered
		st_next.resp    = 1'b0;
		st_next.wr_pend = addr_valid && HWRITE;
		st_next.wr_addr = HADDR[7:0];
		if (addr_valid && !HWRITE)
			st_next.rdata = read_word(st_reg, HADDR[7:0]);

		// bus data phase write decode
		wr_ctrl  = wr_hit(st_reg, tmc_pkg::ADDR_MODE_CLOCK_CTRL);
		wr_force = wr_hit(st_reg, tmc_pkg::ADDR_FORCE_COMPARE);
		wr_low   = wr_hit(st_reg, tmc_pkg::ADDR_MODE_LOW_CTRL);
		wr_stat  = wr_hit(st_reg, tmc_pkg::ADDR_IRQ_STATUS);
		wr_mask  = wr_hit(st_reg, tmc_pkg::ADDR_IRQ_MASK);

		// reserved bit is held at zero whatever software writes
		if (wr_ctrl)
			st_next.ctrl = HWDATA[7:0] & tmc_pkg::CTRL_WRITE_MASK;
		// mode bits 1:0 stand in for the first control register
		if (wr_low)
			st_next.mode_low = HWDATA[1:0];
		if (wr_mask)
			st_next.mask = HWDATA[tmc_pkg::STAT_CAPTURE_BIT];

		// decode reads the registered fields, so a write acts a cycle later
		wgm      = {st_reg.ctrl[tmc_pkg::CTRL_WGM_HI_LSB +: 2], st_reg.mode_low};
		cs       = st_reg.ctrl[tmc_pkg::CTRL_CS_LSB +: 3];
		mode_now = decode_mode(wgm);

		// strobes are not stored; they pulse for one cycle and read back zero
		st_next.force_a = wr_force && HWDATA[tmc_pkg::FORCE_A_BIT] &&
			!is_pwm(mode_now.kind);
		st_next.force_b = wr_force && HWDATA[tmc_pkg::FORCE_B_BIT] &&
			!is_pwm(mode_now.kind);

		// mode decode feeds the counter datapath
		st_next.mode = mode_now;
		// a capture-sourced top trails the capture register by one cycle
		case (mode_now.top_src)
			tmc_pkg::TS_COMPARE_A: st_next.top = COMPARE_A_VALUE;
			tmc_pkg::TS_CAPTURE:   st_next.top = st_reg.cap_val;
			default:               st_next.top = mode_now.fixed_top;
		endcase

		// pin synchronisers; the first stage feeds only the second
		st_next.ext_s1    = EXT_COUNT_INPUT;
		st_next.ext_s2    = st_reg.ext_s1;
		st_next.ext_prev  = st_reg.ext_s2;
		st_next.cap_s1    = CAPTURE_INPUT;
		st_next.cap_s2    = st_reg.cap_s1;
		st_next.filt_prev = cap_bus.filtered;

		// the pin is read back whatever its direction, so driving it steps the counter
		ext_rise = edge_seen(st_reg.ext_s2, st_reg.ext_prev, 1'b1);
		ext_fall = edge_seen(st_reg.ext_s2, st_reg.ext_prev, 1'b0);

		// prescaler runs free; sharing it means a ratio change may shorten the first period
		st_next.presc = st_reg.presc + tmc_pkg::PRESC_W'(1);
		// pin modes tick once per qualifying edge, three cycles after it
		case (cs)
			tmc_pkg::CS_STOPPED:  st_next.tick = 1'b0;
			tmc_pkg::CS_DIV1:     st_next.tick = 1'b1;
			tmc_pkg::CS_DIV8:     st_next.tick = presc_hit(st_reg.presc, tmc_pkg::LOG2_DIV8);
			tmc_pkg::CS_DIV64:    st_next.tick = presc_hit(st_reg.presc, tmc_pkg::LOG2_DIV64);
			tmc_pkg::CS_DIV256:   st_next.tick = presc_hit(st_reg.presc, tmc_pkg::LOG2_DIV256);
			tmc_pkg::CS_DIV1024:  st_next.tick = presc_hit(st_reg.presc, tmc_pkg::LOG2_DIV1024);
			tmc_pkg::CS_EXT_FALL: st_next.tick = ext_fall;
			tmc_pkg::CS_EXT_RISE: st_next.tick = ext_rise;
			default:              st_next.tick = 1'b0;
		endcase

		// input capture
		cap_edge = edge_seen(cap_bus.filtered, st_reg.filt_prev,
			st_reg.ctrl[tmc_pkg::CTRL_EDGE_BIT]);
		cap_from_pin = cap_edge && mode_now.top_src != tmc_pkg::TS_CAPTURE;
		st_next.cap_evt = cap_from_pin;
		if (cap_from_pin)
			st_next.cap_val = COUNTER_VALUE;

		// a set in the same cycle as a clear wins; forced matches never reach here
		st_next.stat = (st_reg.stat && !(wr_stat && HWDATA[tmc_pkg::STAT_CAPTURE_BIT])) ||
			cap_from_pin;
		// the mask gates only the pin; status records every capture
		st_next.irq = st_next.stat && st_next.mask;
	end

	// the only clocked process of this module
	always_ff @(posedge CORE_CLK or negedge RESETN)
	begin
		if (!RESETN)
			st_reg <= ST_RESET;
		else
			st_reg <= st_next;
	end

	// every output is a field of the state register
	assign HRDATA            = st_reg.rdata;
	assign HREADYOUT         = st_reg.ready;
	assign HRESP             = st_reg.resp;
	assign COUNT_TICK        = st_reg.tick;
	assign TOP_VALUE         = st_reg.top;
	assign WAVE_KIND         = st_reg.mode.kind;
	assign COMPARE_UPDATE_AT = st_reg.mode.update_at;
	assign OVERFLOW_AT       = st_reg.mode.overflow_at;
	// forced matches go out on their own lines so the datapath never clears or flags on them
	assign FORCE_MATCH_A     = st_reg.force_a;
	assign FORCE_MATCH_B     = st_reg.force_b;
	assign CAPTURE_EVENT     = st_reg.cap_evt;
	assign CAPTURE_VALUE     = st_reg.cap_val;
	assign IRQ               = st_reg.irq;

endmodule : tmc_timer_ctrl
`default_nettype wire

// ### tmc_timer_ctrl_checker.sv
// concurrent checks on the ports of the timer mode, clock and capture control block
// assumes it is bound onto tmc_timer_ctrl, one clock CORE_CLK, async low reset RESETN
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_ctrl_checker (
	input  wire logic                    CORE_CLK,
	input  wire logic                    RESETN,
	input  wire logic                    HREADYOUT,
	input  wire logic                    HRESP,
	input  wire logic [15:0]             COUNTER_VALUE,
	input  wire logic [15:0]             TOP_VALUE,
	input  wire tmc_pkg::tmc_wave_kind_t WAVE_KIND,
	input  wire tmc_pkg::tmc_point_t     COMPARE_UPDATE_AT,
	input  wire tmc_pkg::tmc_point_t     OVERFLOW_AT,
	input  wire logic                    FORCE_MATCH_A,
	input  wire logic                    FORCE_MATCH_B,
	input  wire logic                    CAPTURE_EVENT,
	input  wire logic [15:0]             CAPTURE_VALUE,
	input  wire logic                    IRQ
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESETN);

	property p_bus_okay;
		HREADYOUT && !HRESP;
	endproperty
	property p_mode_plain;
		WAVE_KIND inside {tmc_pkg::WK_NORMAL, tmc_pkg::WK_CTC} |->
			COMPARE_UPDATE_AT == tmc_pkg::EP_IMMEDIATE && OVERFLOW_AT == tmc_pkg::EP_MAX;
	endproperty
	property p_mode_pc;
		WAVE_KIND == tmc_pkg::WK_PC_PWM |->
			COMPARE_UPDATE_AT == tmc_pkg::EP_TOP && OVERFLOW_AT == tmc_pkg::EP_BOTTOM;
	endproperty
	property p_mode_pfc;
		WAVE_KIND == tmc_pkg::WK_PFC_PWM |->
			COMPARE_UPDATE_AT == tmc_pkg::EP_BOTTOM && OVERFLOW_AT == tmc_pkg::EP_BOTTOM;
	endproperty
	property p_mode_fast;
		WAVE_KIND == tmc_pkg::WK_FAST_PWM |->
			COMPARE_UPDATE_AT == tmc_pkg::EP_TOP && OVERFLOW_AT == tmc_pkg::EP_TOP;
	endproperty
	property p_reserved_top;
		WAVE_KIND == tmc_pkg::WK_RESERVED |-> TOP_VALUE == tmc_pkg::TOP_MAX;
	endproperty
	property p_cap_copy;
		CAPTURE_EVENT |-> CAPTURE_VALUE == $past(COUNTER_VALUE);
	endproperty
	property p_force_mode;
		(FORCE_MATCH_A || FORCE_MATCH_B) |-> WAVE_KIND inside {tmc_pkg::WK_NORMAL, tmc_pkg::WK_CTC};
	endproperty
	property p_force_pulse;
		(FORCE_MATCH_A || FORCE_MATCH_B) |=> !FORCE_MATCH_A && !FORCE_MATCH_B;
	endproperty

	a_bus_okay:     assert property (p_bus_okay) else $error("bus answer not ready okay");
	a_mode_plain:   assert property (p_mode_plain) else $error("plain mode points");
	a_mode_pc:      assert property (p_mode_pc) else $error("phase mode points");
	a_mode_pfc:     assert property (p_mode_pfc) else $error("freq mode points");
	a_mode_fast:    assert property (p_mode_fast) else $error("fast mode points");
	a_reserved_top: assert property (p_reserved_top) else $error("reserved top");
	a_cap_copy:     assert property (p_cap_copy) else $error("capture value");
	a_force_mode:   assert property (p_force_mode) else $error("force in pwm");
	a_force_pulse:  assert property (p_force_pulse) else $error("force not strobe");

	c_capture: cover property (CAPTURE_EVENT);
	c_force:   cover property (FORCE_MATCH_A);
	c_irq:     cover property ($rose(IRQ));
endmodule : tmc_timer_ctrl_checker
`default_nettype wire

// ### tmc_pins_model.sv
// model of the capture pin and the external count pin facing the timer control block
// assumes tasks are called from one process, just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module tmc_pins_model (
	input  wire logic clk,
	output var  logic cap_pin,
	output var  logic cnt_pin
);
	initial
	begin
		cap_pin = 1'b0;
		cnt_pin = 1'b0;
	end
	task automatic cap_set(input logic v, input int hold);
		cap_pin <= v;
		repeat (hold) @(posedge clk);
	endtask : cap_set
	// spacing of six cycles keeps toggles apart through the two-flop synchroniser
	task automatic cnt_toggle(input int n);
		repeat (n)
		begin
			cnt_pin <= ~cnt_pin;
			repeat (6) @(posedge clk);
		end
	endtask : cnt_toggle
endmodule : tmc_pins_model
`default_nettype wire

// ### tmc_timer_ctrl_tb.sv
// self-checking bench for the timer mode, clock and capture control block
// assumes the design package, interface, filter and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_ctrl_tb;
	logic                    clk = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    hsel = 1'b0;
	logic [31:0]             haddr = 32'h0;
	logic [1:0]              htrans = 2'h0;
	logic                    hwrite = 1'b0;
	logic [31:0]             hwdata = 32'h0;
	logic [31:0]             hrdata;
	logic                    hreadyout;
	logic                    hresp;
	logic [15:0]             cnt_val = 16'h0;
	logic [15:0]             cmpa = 16'h0;
	logic [15:0]             top_val;
	logic [15:0]             cap_val;
	logic [15:0]             exp_cap = 16'h0;
	logic                    count_tick, force_a, force_b, cap_event, cap_pin, ext_pin, irq;
	tmc_pkg::tmc_wave_kind_t wave_kind;
	tmc_pkg::tmc_point_t     upd_at, ovf_at;
	logic [31:0]             rdat;
	int                      fail_count = 0, n_tests = 0, seed = 17;
	int                      cap_cnt = 0, tick_cnt = 0, fa_cnt = 0, fb_cnt = 0;
	int                      sh [6] = '{0, 0, 3, 6, 8, 10};

	tmc_timer_ctrl tmc_timer_ctrl_i (.CORE_CLK(clk), .RESETN(rst_n), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.COUNTER_VALUE(cnt_val), .COMPARE_A_VALUE(cmpa), .COUNT_TICK(count_tick),
		.TOP_VALUE(top_val), .WAVE_KIND(wave_kind), .COMPARE_UPDATE_AT(upd_at),
		.OVERFLOW_AT(ovf_at), .FORCE_MATCH_A(force_a), .FORCE_MATCH_B(force_b),
		.CAPTURE_EVENT(cap_event), .CAPTURE_VALUE(cap_val), .CAPTURE_INPUT(cap_pin),
		.EXT_COUNT_INPUT(ext_pin), .IRQ(irq));
	tmc_pins_model tmc_pins_model_i (.clk(clk), .cap_pin(cap_pin), .cnt_pin(ext_pin));

	initial
	begin
		forever #50 clk = ~clk;
	end
	// counters update by non-blocking assignment so readers after an edge see a stable value
	always @(posedge clk)
	begin
		cnt_val <= cnt_val + 16'h1;
		tick_cnt <= tick_cnt + ((count_tick === 1'b1) ? 1 : 0);
		fa_cnt <= fa_cnt + ((force_a === 1'b1) ? 1 : 0);
		fb_cnt <= fb_cnt + ((force_b === 1'b1) ? 1 : 0);
		if (cap_event === 1'b1)
		begin
			cap_cnt <= cap_cnt + 1;
			exp_cap <= cnt_val - 16'h1;
		end
	end

	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rdat = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask : rd
	// pin high for hold cycles then low; event counts checked mid-way when hold is at least 12, and at the end
	task automatic cap_step(input logic [7:0] c, input int hold, input int em, input int ee);
		int c0;
		wr(8'h00, {24'h0, c});
		c0 = cap_cnt;
		tmc_pins_model_i.cap_set(1'b1, hold);
		if (hold >= 12)
			chk(32'(cap_cnt - c0), 32'(em));
		tmc_pins_model_i.cap_set(1'b0, 12);
		chk(32'(cap_cnt - c0), 32'(ee));
	endtask : cap_step
	function automatic logic [22:0] mexp(input int m, input logic [15:0] ca, input logic [15:0] cp);
		tmc_pkg::tmc_wave_kind_t k;
		tmc_pkg::tmc_point_t     u, o;
		logic [15:0]             t;
		case (m)
			0, 13:           k = tmc_pkg::WK_NORMAL;
			4, 12:           k = tmc_pkg::WK_CTC;
			8, 9:            k = tmc_pkg::WK_PFC_PWM;
			5, 6, 7, 14, 15: k = tmc_pkg::WK_FAST_PWM;
			default:         k = tmc_pkg::WK_PC_PWM;
		endcase
		case (m)
			1, 5:           t = tmc_pkg::TOP_8BIT;
			2, 6:           t = tmc_pkg::TOP_9BIT;
			3, 7:           t = tmc_pkg::TOP_10BIT;
			4, 9, 11, 15:   t = ca;
			8, 10, 12, 14:  t = cp;
			default:        t = tmc_pkg::TOP_MAX;
		endcase
		u = (k == tmc_pkg::WK_PFC_PWM) ? tmc_pkg::EP_BOTTOM : tmc_pkg::EP_TOP;
		o = (k == tmc_pkg::WK_FAST_PWM) ? tmc_pkg::EP_TOP : tmc_pkg::EP_BOTTOM;
		if (k == tmc_pkg::WK_NORMAL || k == tmc_pkg::WK_CTC)
		begin
			u = tmc_pkg::EP_IMMEDIATE;
			o = tmc_pkg::EP_MAX;
		end
		return {k, u, o, t};
	endfunction : mexp

	initial
	begin
		int          f0, g0, t0;
		logic        plain, ctop;
		logic [7:0]  mc;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk(32'({wave_kind, upd_at, ovf_at, top_val}), 32'(mexp(0, 16'h0, 16'h0)));
		for (int a = 0; a <= 32; a += 4)
			rd(8'(a), 32'h0);
		wr(8'h14, 32'h1);
		cap_step(8'h40, 12, 1, 1);
		cap_step(8'h00, 12, 0, 1);
		cap_step(8'hc0, 3, 0, 0);
		cap_step(8'hc0, 4, 0, 1);
		rd(8'h0c, {16'h0, exp_cap});
		chk({31'h0, irq}, 32'h1);
		rd(8'h10, 32'h1);
		wr(8'h10, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		for (int m = 0; m < 16; m++)
		begin
			cmpa <= 16'($random(seed));
			mc = 8'h40 | {3'h0, 2'(m >> 2), 3'h0};
			wr(8'h08, 32'(m & 3));
			wr(8'h00, {24'h0, mc});
			repeat (3) @(posedge clk);
			if (m == 13)
				chk(32'({wave_kind, top_val}), {13'h0, tmc_pkg::WK_RESERVED, tmc_pkg::TOP_MAX});
			else
				chk(32'({wave_kind, upd_at, ovf_at, top_val}), 32'(mexp(m, cmpa, exp_cap)));
			f0 = fa_cnt;
			g0 = fb_cnt;
			plain = (m == 0 || m == 4 || m == 12);
			wr(8'h04, 32'hc0);
			repeat (3) @(posedge clk);
			chk(32'(fa_cnt - f0), 32'(plain));
			chk(32'(fb_cnt - g0), 32'(plain));
			chk({31'h0, irq}, 32'h0);
			rd(8'h04, 32'h0);
			ctop = (m == 8 || m == 10 || m == 12 || m == 14);
			cap_step(mc, 12, int'(!ctop), int'(!ctop));
			wr(8'h10, 32'h1);
		end
		wr(8'h08, 32'h0);
		for (int c = 0; c < 6; c++)
		begin
			wr(8'h00, 32'(c));
			repeat (8) @(posedge clk);
			t0 = tick_cnt;
			repeat (2048) @(posedge clk);
			chk(32'(tick_cnt - t0), (c == 0) ? 32'h0 : 32'(2048 >> sh[c]));
		end
		// from low, five toggles give two falls; from high, five give two rises
		for (int c = 6; c < 8; c++)
		begin
			wr(8'h00, 32'(c));
			repeat (8) @(posedge clk);
			t0 = tick_cnt;
			tmc_pins_model_i.cnt_toggle(5);
			repeat (8) @(posedge clk);
			chk(32'(tick_cnt - t0), 32'h2);
		end
		results();
	end
	initial
	begin
		#3000000;
		fail_count++;
		results();
	end
endmodule : tmc_timer_ctrl_tb

bind tmc_timer_ctrl tmc_timer_ctrl_checker tmc_timer_ctrl_checker_i (
	.CORE_CLK(CORE_CLK), .RESETN(RESETN), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.COUNTER_VALUE(COUNTER_VALUE), .TOP_VALUE(TOP_VALUE), .WAVE_KIND(WAVE_KIND),
	.COMPARE_UPDATE_AT(COMPARE_UPDATE_AT), .OVERFLOW_AT(OVERFLOW_AT),
	.FORCE_MATCH_A(FORCE_MATCH_A), .FORCE_MATCH_B(FORCE_MATCH_B),
	.CAPTURE_EVENT(CAPTURE_EVENT), .CAPTURE_VALUE(CAPTURE_VALUE), .IRQ(IRQ));
`default_nettype wire
